// file: hw/sst_pkg.sv
// Shared constants and types of the SRAM boundary-scan test port
`default_nettype none
package sst_pkg;
    // ==========================================================
    // Register sizes
    localparam int BSR_LEN = 109;
    localparam int TRI_CELL = 108;
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    // ==========================================================
    // Instruction codes
    localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] INS_IDENT = 3'h1;
    localparam logic [IR_LEN-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;
    // Capture-IR pattern, low two bits 01
    localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
    // ==========================================================
    // Reset values
    localparam logic TRI_PRESET = 1'h0;
    localparam logic BYPASS_CAPTURE = 1'h0;
    localparam logic ID_PRESENCE = 1'h1;
    localparam int TLR_TMS_EDGES = 5;
    // ==========================================================
    // Test port controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } sst_tap_type;
endpackage : sst_pkg
`default_nettype wire

// file: hw/sst_sync.sv
// Two-flop synchroniser for pin-level inputs
`default_nettype none
module sst_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sst_sync_type;

    sst_sync_type st_r;
    sst_sync_type st_nxt;

    always_comb begin
        st_nxt.meta = d;
        // First stage feeds only the second
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stable;
endmodule : sst_sync
`default_nettype wire

// file: hw/sst_tap.sv
// Boundary-scan test access port of the synchronous SRAM
// Overview of operation
// (R01) Capture-DR loads ring; Shift-DR shifts boundary
// (R02) Chain includes unused-pin cells, fixed length
// (R03) Shift in at MSB, out at LSB
// (R04) Ring capture under extest, sample, float
// (R05) Identification word captured, then shifted out
// (R06) Three-bit instruction, five codes implemented
// (R07) Instruction shifted, takes effect at Update-IR
// (R08) Reset forces identification instruction current
// (R09) Float instruction: boundary chain, outputs high-Z
// (R10) Sample snapshots pins, memory undisturbed
// (R11) Tester keeps clock slow, inputs stable
// (R12) Update-DR latches pattern into cell outputs
// (R13) Shift out capture while shifting in preload
// (R14) Bypass routes single cell in Shift-DR
// (R15) Extest drives preloaded cells onto outputs
// (R16) Cell 108 gates read bus under extest
// (R17) Tester sets cell via sample or extest
// (R18) Control cell preset on reset
// (R19) Tester never loads reserved codes
// (R20) Fixed instruction encodings
// (R21) Capture-IR loads 01 into low bits
// (R22) Five high mode-select edges reset port
// (R23) Sample on rise, drive TDO on fall
// (R24) Sixteen-state controller, TDO only when shifting
// (R25) Bypass captures zero
`default_nettype none
module sst_tap
    import sst_pkg::*;
#(
    // Arbitrary neutral identification fields
    parameter logic [2:0] ID_REVISION = 3'h0,
    parameter logic [16:0] ID_DEVICE = 17'h00001,
    parameter logic [10:0] ID_MAKER = 11'h001
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Serial test link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Memory pin ring
    input wire logic [sst_pkg::BSR_LEN-1:0] ring_in,
    output logic [sst_pkg::TRI_CELL-1:0] bsr_out,
    output logic extest_drive,
    output logic q_oe
);
    import sst_pkg::*;

    localparam logic [ID_LEN-1:0] ID_WORD = {ID_REVISION, ID_DEVICE, ID_MAKER, ID_PRESENCE};

    typedef struct packed {
        sst_tap_type tap;
        logic tck_prev;
        logic [IR_LEN-1:0] ir_shift;
        logic [IR_LEN-1:0] ir_cur;
        logic bypass;
        logic [ID_LEN-1:0] id_shift;
        logic [BSR_LEN-1:0] bsr_shift;
        logic [BSR_LEN-1:0] bsr_upd;
        logic tdo;
        logic tdo_oe;
        logic extest_drive;
        logic q_oe;
    } sst_state_type;

    sst_state_type st_r;
    sst_state_type st_nxt;
    logic [2:0] pin_s;
    logic [BSR_LEN-1:0] ring_s;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic rise;
    logic fall;

    // ==========================================================
    // Pin synchronisers
    sst_sync #(.W(3)) u_pin_sync (
        .clock(clock),
        .srst(srst),
        .d({tck, tms, tdi}),
        .q(pin_s)
    );

    // Ring sampled like any pin; unstable bits may read either way
    sst_sync #(.W(BSR_LEN)) u_ring_sync (
        .clock(clock),
        .srst(srst),
        .d(ring_in),
        .q(ring_s)
    );

    assign tck_s = pin_s[2];
    assign tms_s = pin_s[1];
    assign tdi_s = pin_s[0];
    assign rise = tck_s & ~st_r.tck_prev;
    assign fall = ~tck_s & st_r.tck_prev;

    // ==========================================================
    // Helpers
    function automatic sst_tap_type tap_next(input sst_tap_type s, input logic m);
        unique case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction : tap_next

    // Instructions that put the boundary chain on the serial path
    function automatic logic sel_bsr(input logic [IR_LEN-1:0] ir);
        sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLE) || (ir == INS_SAMPLE_Z);
    endfunction : sel_bsr

    // Reserved codes fall back to the bypass cell
    function automatic logic sel_bypass(input logic [IR_LEN-1:0] ir);
        sel_bypass = !sel_bsr(ir) && (ir != INS_IDENT);
    endfunction : sel_bypass

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.tck_prev = tck_s;
        if (rise) begin // R23
            st_nxt.tap = tap_next(st_r.tap, tms_s); // R24 R22
            unique case (st_r.tap)
                TAP_CAP_DR: begin
                    if (sel_bsr(st_r.ir_cur)) begin
                        st_nxt.bsr_shift = ring_s; // R01 R04 R10 R02
                    end else if (st_r.ir_cur == INS_IDENT) begin
                        st_nxt.id_shift = ID_WORD; // R05
                    end else if (sel_bypass(st_r.ir_cur)) begin
                        st_nxt.bypass = BYPASS_CAPTURE; // R25
                    end
                end
                TAP_SHIFT_DR: begin
                    // Capture goes out while new pattern comes in
                    if (sel_bsr(st_r.ir_cur)) begin
                        st_nxt.bsr_shift = {tdi_s, st_r.bsr_shift[BSR_LEN-1:1]}; // R03 R13 R09
                    end else if (st_r.ir_cur == INS_IDENT) begin
                        st_nxt.id_shift = {tdi_s, st_r.id_shift[ID_LEN-1:1]}; // R05
                    end else if (sel_bypass(st_r.ir_cur)) begin
                        st_nxt.bypass = tdi_s; // R14
                    end
                end
                TAP_UPD_DR: begin
                    if (st_r.ir_cur == INS_EXTEST || st_r.ir_cur == INS_SAMPLE) begin
                        st_nxt.bsr_upd = st_r.bsr_shift; // R12 R16
                    end
                end
                TAP_CAP_IR: st_nxt.ir_shift = IR_CAPTURE_VAL; // R21
                TAP_SHIFT_IR: st_nxt.ir_shift = {tdi_s, st_r.ir_shift[IR_LEN-1:1]}; // R03 R07
                TAP_UPD_IR: st_nxt.ir_cur = st_r.ir_shift; // R07 R06 R20
                default: ;
            endcase
            if (st_nxt.tap == TAP_RESET) begin
                st_nxt.ir_cur = INS_IDENT; // R08
                st_nxt.bsr_upd[TRI_CELL] = TRI_PRESET; // R18
            end
        end
        if (fall) begin
            // TDO changes only on the falling link edge
            st_nxt.tdo_oe = (st_r.tap == TAP_SHIFT_DR) || (st_r.tap == TAP_SHIFT_IR); // R24
            if (st_r.tap == TAP_SHIFT_IR) begin
                st_nxt.tdo = st_r.ir_shift[0]; // R03 R23
            end else if (sel_bsr(st_r.ir_cur)) begin
                st_nxt.tdo = st_r.bsr_shift[0];
            end else if (st_r.ir_cur == INS_IDENT) begin
                st_nxt.tdo = st_r.id_shift[0];
            end else if (sel_bypass(st_r.ir_cur)) begin
                st_nxt.tdo = st_r.bypass;
            end
        end
        st_nxt.extest_drive = (st_nxt.ir_cur == INS_EXTEST); // R15
        if (st_nxt.ir_cur == INS_SAMPLE_Z) begin
            st_nxt.q_oe = 1'h0; // R09
        end else if (st_nxt.ir_cur == INS_EXTEST) begin
            st_nxt.q_oe = st_nxt.bsr_upd[TRI_CELL]; // R16
        end else begin
            st_nxt.q_oe = 1'h1; // R10
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
            st_r.tap <= TAP_RESET;
            st_r.ir_cur <= INS_IDENT; // R08
            st_r.ir_shift <= IR_CAPTURE_VAL;
            st_r.bsr_upd[TRI_CELL] <= TRI_PRESET; // R18
            st_r.q_oe <= 1'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tdo = st_r.tdo;
    assign tdo_oe = st_r.tdo_oe;
    assign bsr_out = st_r.bsr_upd[TRI_CELL-1:0];
    assign extest_drive = st_r.extest_drive;
    assign q_oe = st_r.q_oe;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Counts high mode-select rises, saturating at the reset count
    localparam logic [2:0] TMS_FULL = 3'(TLR_TMS_EDGES);
    logic [2:0] tms_cnt_r;
    always_ff @(posedge clock) begin
        if (srst) begin
            tms_cnt_r <= '0;
        end else if (rise) begin
            tms_cnt_r <= tms_s ? ((tms_cnt_r == TMS_FULL) ? TMS_FULL : tms_cnt_r + 3'h1) : 3'h0;
        end
    end

    tms_reset_a: assert property (tms_cnt_r == TMS_FULL |-> st_r.tap == TAP_RESET) // R22
        else $error("five high mode edges did not reset port");
    reset_ident_a: assert property (st_r.tap == TAP_RESET |-> ##1 st_r.ir_cur == INS_IDENT) // R08
        else $error("reset state without identification instruction");
    ir_update_a: assert property (rise && st_r.tap == TAP_UPD_IR // R07
        |=> st_r.ir_cur == $past(st_r.ir_shift))
        else $error("instruction not made current at update");
    ir_stable_a: assert property (st_r.tap != TAP_UPD_IR && st_r.tap != TAP_RESET // R07
        && !(st_r.tap == TAP_SEL_IR && tms_s)
        |=> $stable(st_r.ir_cur))
        else $error("instruction changed outside update");
    ir_capture_a: assert property (rise && st_r.tap == TAP_CAP_IR // R21
        |=> st_r.ir_shift[1:0] == 2'h1)
        else $error("capture pattern wrong");
    id_capture_a: assert property (rise && st_r.tap == TAP_CAP_DR // R05
        && st_r.ir_cur == INS_IDENT
        |=> st_r.id_shift == ID_WORD && st_r.id_shift[0] == 1'h1)
        else $error("identification word not captured");
    float_q_a: assert property (st_r.ir_cur == INS_SAMPLE_Z |-> !q_oe) // R09
        else $error("read bus driven under float instruction");
    tri_cell_a: assert property (st_r.ir_cur == INS_EXTEST // R16
        |-> q_oe == st_r.bsr_upd[TRI_CELL])
        else $error("control cell not gating read bus");
    tdo_fall_a: assert property (!fall |=> $stable(tdo) && $stable(tdo_oe)) // R23
        else $error("serial output moved off falling edge");
    tdo_oe_a: assert property (fall && st_r.tap != TAP_SHIFT_DR && st_r.tap != TAP_SHIFT_IR // R24
        |=> !tdo_oe)
        else $error("serial output driven outside shift");

    // ==========================================================
    // Controller checks
    tap_hold_a: assert property (!rise |=> $stable(st_r.tap)) // R23
        else $error("controller moved without a rising link edge");
    reset_exit_a: assert property (rise && st_r.tap == TAP_RESET && !tms_s // R24
        |=> st_r.tap == TAP_IDLE)
        else $error("reset state not left on low mode select");
    shift_enter_a: assert property (rise && st_r.tap == TAP_CAP_DR && !tms_s // R24
        |=> st_r.tap == TAP_SHIFT_DR)
        else $error("capture did not lead into shift");
    update_idle_a: assert property (rise && st_r.tap == TAP_UPD_IR && !tms_s // R24
        |=> st_r.tap == TAP_IDLE)
        else $error("update did not return to idle");
    sel_reset_a: assert property (rise && st_r.tap == TAP_SEL_IR && tms_s // R08 R24
        |=> st_r.tap == TAP_RESET && st_r.ir_cur == INS_IDENT)
        else $error("reset entry did not restore identification");

    // ==========================================================
    // Serial path checks
    ir_shift_a: assert property (rise && st_r.tap == TAP_SHIFT_IR // R03 R07
        |=> st_r.ir_shift == {$past(tdi_s), $past(st_r.ir_shift[IR_LEN-1:1])})
        else $error("instruction bit not shifted toward bit 0");
    bsr_shift_a: assert property (rise && st_r.tap == TAP_SHIFT_DR // R03 R13
        && sel_bsr(st_r.ir_cur)
        |=> st_r.bsr_shift == {$past(tdi_s), $past(st_r.bsr_shift[BSR_LEN-1:1])})
        else $error("boundary chain not shifted toward bit 0");
    id_shift_a: assert property (rise && st_r.tap == TAP_SHIFT_DR // R03 R05
        && st_r.ir_cur == INS_IDENT
        |=> st_r.id_shift == {$past(tdi_s), $past(st_r.id_shift[ID_LEN-1:1])})
        else $error("identification word not shifted toward bit 0");
    bypass_shift_a: assert property (rise && st_r.tap == TAP_SHIFT_DR // R14
        && sel_bypass(st_r.ir_cur)
        |=> st_r.bypass == $past(tdi_s))
        else $error("bypass cell did not take serial input");
    bypass_zero_a: assert property (rise && st_r.tap == TAP_CAP_DR // R25
        && sel_bypass(st_r.ir_cur)
        |=> st_r.bypass == 1'h0)
        else $error("bypass cell did not capture zero");
    tdo_bsr_a: assert property (fall && st_r.tap == TAP_SHIFT_DR // R03 R24
        && sel_bsr(st_r.ir_cur)
        |=> tdo == $past(st_r.bsr_shift[0]) && tdo_oe)
        else $error("boundary bit 0 not presented");
    tdo_id_a: assert property (fall && st_r.tap == TAP_SHIFT_DR // R03 R05
        && st_r.ir_cur == INS_IDENT
        |=> tdo == $past(st_r.id_shift[0]) && tdo_oe)
        else $error("identification bit 0 not presented");
    tdo_bypass_a: assert property (fall && st_r.tap == TAP_SHIFT_DR // R14
        && sel_bypass(st_r.ir_cur)
        |=> tdo == $past(st_r.bypass) && tdo_oe)
        else $error("bypass cell not presented");
    tdo_ir_a: assert property (fall && st_r.tap == TAP_SHIFT_IR // R03 R24
        |=> tdo == $past(st_r.ir_shift[0]) && tdo_oe)
        else $error("instruction bit 0 not presented");

    // ==========================================================
    // Boundary cell checks
    bsr_capture_a: assert property (rise && st_r.tap == TAP_CAP_DR // R01 R04 R10
        && sel_bsr(st_r.ir_cur)
        |=> st_r.bsr_shift == $past(ring_s))
        else $error("pin ring not captured");
    bsr_latch_a: assert property (rise && st_r.tap == TAP_UPD_DR // R12 R16
        && (st_r.ir_cur == INS_EXTEST || st_r.ir_cur == INS_SAMPLE)
        |=> st_r.bsr_upd == $past(st_r.bsr_shift))
        else $error("pattern not latched at update");
    bsr_keep_a: assert property (rise && st_r.tap == TAP_UPD_DR // R12 R09
        && !(st_r.ir_cur == INS_EXTEST || st_r.ir_cur == INS_SAMPLE)
        |=> $stable(st_r.bsr_upd))
        else $error("update stage latched under wrong instruction");
    bsr_out_a: assert property (!rise || st_r.tap != TAP_UPD_DR |=> $stable(bsr_out)) // R12
        else $error("cell outputs moved outside update");
    tri_preset_a: assert property (st_r.tap == TAP_RESET // R18
        |-> st_r.bsr_upd[TRI_CELL] == TRI_PRESET)
        else $error("control cell not preset in reset state");
    extest_out_a: assert property (extest_drive == (st_r.ir_cur == INS_EXTEST)) // R15
        else $error("pin drive does not follow external test");
    q_oe_normal_a: assert property (st_r.ir_cur != INS_EXTEST // R10
        && st_r.ir_cur != INS_SAMPLE_Z |-> q_oe)
        else $error("read bus disturbed outside test instructions");

    // ==========================================================
    // Scenario covers
    ir_load_c: cover property (rise && st_r.tap == TAP_UPD_IR);
    extest_c: cover property (st_r.ir_cur == INS_EXTEST && q_oe);
    float_c: cover property (st_r.ir_cur == INS_SAMPLE_Z);
    preload_c: cover property (rise && st_r.tap == TAP_UPD_DR && st_r.ir_cur == INS_SAMPLE);
    bypass_c: cover property (rise && st_r.tap == TAP_SHIFT_DR && sel_bypass(st_r.ir_cur));
endmodule : sst_tap
`default_nettype wire

// file: test/sst_tap_bench.sv
// Self-checking bench of the boundary-scan test port
`default_nettype none
module sst_tap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sst_pkg::*;
    // Arbitrary identification fields
    localparam logic [31:0] ID_WORD = {3'h5, 17'h0A5A5, 11'h2B3, 1'h1};
    localparam logic [108:0] RING_A = {1'h1, {27{4'h6}}};
    localparam logic [108:0] RING_B = ~RING_A;
    localparam logic [108:0] PRE_A = {1'h0, {27{4'hC}}};
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [108:0] ring_in = '0;
    logic tck, tms, tdi, tdo, tdo_oe, extest_drive, q_oe;
    logic [107:0] bsr_out;
    logic [127:0] d;
    int n_errors = 0;
    int n_compared = 0;

    always #2.5 clock = ~clock;

    sst_tap #(.ID_REVISION(3'h5), .ID_DEVICE(17'h0A5A5), .ID_MAKER(11'h2B3)) u_sst_tap (
        .clock(clock), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .ring_in(ring_in), .bsr_out(bsr_out),
        .extest_drive(extest_drive), .q_oe(q_oe));

    sst_tester u_sst_tester (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic load(input logic [2:0] code);
        u_sst_tester.scan(1'b1, 3, {125'h0, code}, d);
        chk(d[1:0], 2'h1);
    endtask : load

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk({extest_drive, q_oe, tdo_oe}, 3'h2);
        chk(bsr_out, 108'h0);
        u_sst_tester.reset_port();
        u_sst_tester.scan(1'b0, 32, '0, d);
        chk(d, ID_WORD);
    endtask : t_reset

    task automatic t_sample;
        ring_in <= RING_A;
        load(INS_SAMPLE);
        chk({extest_drive, q_oe}, 2'h1);
        u_sst_tester.scan(1'b0, 109, PRE_A, d);
        chk(d, RING_A);
        chk(bsr_out, PRE_A[107:0]);
    endtask : t_sample

    task automatic t_extest;
        load(INS_EXTEST);
        chk({extest_drive, q_oe}, 2'h2);
        ring_in <= RING_B;
        u_sst_tester.scan(1'b0, 109, {1'h1, ~PRE_A[107:0]}, d);
        chk(d, RING_B);
        chk({q_oe, bsr_out}, {1'h1, ~PRE_A[107:0]});
    endtask : t_extest

    task automatic t_float;
        load(INS_SAMPLE_Z);
        chk({extest_drive, q_oe}, 2'h0);
        u_sst_tester.scan(1'b0, 109, PRE_A, d);
        chk(d, RING_B);
        chk({q_oe, bsr_out}, {1'h0, ~PRE_A[107:0]});
    endtask : t_float

    task automatic t_bypass;
        load(INS_BYPASS);
        chk({extest_drive, q_oe}, 2'h1);
        u_sst_tester.scan(1'b0, 4, 128'hB, d);
        chk(d, 128'h6);
        chk(tdo_oe, 1'h0);
    endtask : t_bypass

    // Port reset from extest brings back identification and the floating preset
    task automatic t_tlr;
        load(INS_EXTEST);
        u_sst_tester.reset_port();
        chk({extest_drive, q_oe}, 2'h1);
        u_sst_tester.scan(1'b0, 32, '0, d);
        chk(d, ID_WORD);
        load(INS_EXTEST);
        chk({extest_drive, q_oe}, 2'h2);
    endtask : t_tlr

    // ==========================================================
    // Main sequence and hang guard
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_sample();
        t_extest();
        t_float();
        t_bypass();
        t_tlr();
        results();
    end

    initial begin
        repeat (95000) @(posedge clock);
        n_errors++;
        results();
    end
endmodule : sst_tap_bench
`default_nettype wire

// file: test/sst_tester.sv
// Behavioural model of the external tester driving the serial test link
`default_nettype none
module sst_tester (
    // Clock
    input wire logic clock,
    // Serial test link
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle at the pulled-up levels, test clock parked low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // ==========================================================
    // One test clock period: 32 system clocks, 15 low and 17 high, 6.25 MHz
    task automatic step(input logic m, input logic d, output logic b);
        @(posedge clock);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (15) @(posedge clock);
        // Undriven output reads as unknown so it can never match
        b = (tdo_oe === 1'b1) ? tdo : 1'bx;
        tck <= 1'b1;
        repeat (16) @(posedge clock);
    endtask : step
    // ==========================================================
    // Five high mode-select edges, then park in Run-Test/Idle
    task automatic reset_port;
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask : reset_port
    // ==========================================================
    // Full scan from Idle back to Idle; bit 0 enters and leaves first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (ir) begin
            step(1'b1, 1'b1, b);
        end
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask : scan
endmodule : sst_tester
`default_nettype wire
